// [hdl/pcrr_cfg.svh]
// Purpose: Constants for the power, clock and reset control register bank
// Assumes: Byte addresses within the die-to-die global address space
// Notes:   Offsets are relative to the blocking or non-blocking window base
`ifndef PCRR_CFG_SVH
`define PCRR_CFG_SVH
`define PCRR_BASE_BLOCKING    16'h0200
`define PCRR_BASE_NONBLOCKING 16'h0300
`define PCRR_WIN_SIZE         16'h0100
`define PCRR_OFS_CTL          8'h00
`define PCRR_OFS_SR_HI        8'h02
`define PCRR_OFS_SR_LO        8'h03
`define PCRR_OFS_TICK_DIVIDER_VALUE        8'h04
`define PCRR_OFS_WUE_HI       8'h06
`define PCRR_OFS_WUE_LO       8'h07
`define PCRR_OFS_TRIM_HI      8'h0E
`define PCRR_OFS_TRIM_LO      8'h0F
`define PCRR_BIT_HOT_GUARD    15
`define PCRR_BIT_UV_GUARD     14
`define PCRR_BIT_HWR_GUARD    13
`define PCRR_BIT_HOT_DIS      7
`define PCRR_BIT_UV_DIS       6
`define PCRR_BIT_HWR          5
`define PCRR_BIT_HOT_FLAG     7
`define PCRR_BIT_UV_FLAG      6
`define PCRR_BIT_HWR_FLAG     5
`define PCRR_BIT_TRIM_FLAG    15
`define PCRR_RST_CTL          16'h0000
`define PCRR_RST_TICK_DIVIDER_VALUE        16'h0000
`define PCRR_RST_WUE          8'h00
`define PCRR_HWR_PULSE_CYC    4'h8
`endif

// [hdl/pcrr_pkg.sv]
// Purpose: Types for the power, clock and reset control register bank
// Assumes: Constants live in pcrr_cfg.svh
// Notes:   Carrier struct for one bus access
package pcrr_pkg;
    typedef enum logic [1:0] {
        PCRR_MODE_NORMAL   = 2'b00,
        PCRR_MODE_STOP     = 2'b01,
        PCRR_MODE_SLEEP    = 2'b10,
        PCRR_MODE_CRANKING = 2'b11
    } pcrr_mode_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        word;
        logic [15:0] addr;
        logic [15:0] wdata;
    } pcrr_req_t;
endpackage

// [hdl/pcrr_regs.sv]
// Purpose: Power, clock and reset control register bank of the analog die
// Assumes: Single-cycle die-to-die access, big-endian words (high byte at even offset)
// Notes:   Guard bits are write-only qualifiers and are never stored
// Functional notes
// - Decode offsets from base 0x0200 blocking or 0x300 non-blocking.
// - Registers without low-byte address only work with 16-bit word accesses.
// - Hot interrupt disable bit 7 updates only with guard bit 15 set.
// - Under-voltage interrupt disable bit 6 updates only with guard bit 14.
// - Hard reset command bit 5 acts only when guard bit 13 set.
// - Tick factor bits 3:2 load only when guard bits 11:10 equal 11.
// - Mode bits 1:0 load only when guard bits 9:8 equal 11.
// - Hot interrupt enabled when its bit is 0, disabled when 1.
// - Under-voltage interrupt enabled when its bit is 0, disabled when 1.
// - Effective hard reset write resets die logic and pulses external reset; reads 0.
// - Tick factor codes 00,01,10,11 give divide by 1,2,4,8.
// - Mode codes 00 normal, 01 stop, 10 sleep.
// - Mode 11 is cranking if feature enabled, else behaves as stop.
// - Sixteen-bit read/write millisecond prescaler register.
// - Read-only trim word: flag bit 15, trimmed value bits 12:0.
// - Hot and under-voltage flags are live; write 1 clears pending interrupt.
`include "pcrr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pcrr_regs
    import pcrr_pkg::*;
#(
    parameter int PULSE_W = 4
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire pcrr_req_t         busReq,
    input  wire logic              blocking,
    output logic [15:0]            busRdata,
    output logic                   busHit,
    input  wire logic              crankingEnable,
    input  wire logic              hotCondition,
    input  wire logic              undervoltCondition,
    input  wire logic [5:0]        resetCauseSet,
    input  wire logic [7:0]        wakeSourceSet,
    input  wire logic              trimStatusFlag,
    input  wire logic [12:0]       trimmedTickDivider,
    output pcrr_mode_t             opMode,
    output logic [3:0]             tickFactor,
    output logic [15:0]            tickDividerValue,
    output logic [7:0]             wakeEnableHigh,
    output logic                   lifetimeCounterWakeEnable,
    output logic                   hotInterrupt,
    output logic                   undervoltInterrupt,
    output logic                   dieLogicReset,
    output logic                   analogResetOutN
);
    logic                 hotDis_q;
    logic                 uvDis_q;
    logic [1:0]           tickSel_q;
    pcrr_mode_t           mode_q;
    logic [15:0]          tick_divider_value_q;
    logic [7:0]           wue_q;
    logic                 lifetime_counter_wake_enable_q;
    logic [7:0]           srHi_q;
    logic [7:0]           srLo_q;
    logic                 hotPend_q;
    logic                 uvPend_q;
    logic                 hotCond_m;
    logic                 hotCond_q;
    logic                 uvCond_m;
    logic                 uvCond_q;
    logic [PULSE_W-1:0]   hwrCnt_q;
    logic                 hwrLatch_q;
    logic [15:0]          rdata_q;

    logic                 inWin;
    logic [7:0]           ofs;
    logic                 wr;
    logic                 rd;
    logic [15:0]          wd;
    logic                 hwrFire;
    logic                 softRst;

    // Window decode per access kind
    always_comb begin
        inWin = 1'b0;
        ofs   = 8'h00;
        if (blocking && busReq.addr >= `PCRR_BASE_BLOCKING &&
            busReq.addr < `PCRR_BASE_BLOCKING + `PCRR_WIN_SIZE) begin
            inWin = 1'b1;
            ofs   = busReq.addr[7:0];
        end else if (!blocking && busReq.addr >= `PCRR_BASE_NONBLOCKING &&
            busReq.addr < `PCRR_BASE_NONBLOCKING + `PCRR_WIN_SIZE) begin
            inWin = 1'b1;
            ofs   = busReq.addr[7:0];
        end
    end

    assign busHit = busReq.valid && inWin;
    assign wr     = busHit && busReq.write;
    assign rd     = busHit && !busReq.write;
    assign wd     = busReq.wdata;

    // Only a word write with the guard set fires the reset command
    assign hwrFire = wr && busReq.word && ofs == `PCRR_OFS_CTL &&
                     wd[`PCRR_BIT_HWR_GUARD] && wd[`PCRR_BIT_HWR];
    // Reserved bits 12 and 4 are simply not stored, so host slips are harmless
    assign softRst = rst || hwrLatch_q;

    // Byte writes to the control word are dropped, it has no low-byte address
    logic ctlWr;
    assign ctlWr = wr && busReq.word && ofs == `PCRR_OFS_CTL;

    // One flop group per guarded field, so a write touches any subset of them
    always_ff @(posedge core_clk) begin
        if (softRst) begin
            hotDis_q <= 1'b0;
        end else if (ctlWr && wd[`PCRR_BIT_HOT_GUARD]) begin
            hotDis_q <= wd[`PCRR_BIT_HOT_DIS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (softRst) begin
            uvDis_q <= 1'b0;
        end else if (ctlWr && wd[`PCRR_BIT_UV_GUARD]) begin
            uvDis_q <= wd[`PCRR_BIT_UV_DIS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (softRst) begin
            tickSel_q <= 2'b00;
        end else if (ctlWr && wd[11:10] == 2'b11) begin
            tickSel_q <= wd[3:2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (softRst) begin
            mode_q <= PCRR_MODE_NORMAL;
        end else if (ctlWr && wd[9:8] == 2'b11) begin
            mode_q <= pcrr_mode_t'(wd[1:0]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (softRst) begin
            tick_divider_value_q <= `PCRR_RST_TICK_DIVIDER_VALUE;
        end else if (wr && busReq.word && ofs == `PCRR_OFS_TICK_DIVIDER_VALUE) begin
            tick_divider_value_q <= wd;
        end
    end

    // Wake enables have separate byte addresses, so byte writes are allowed
    always_ff @(posedge core_clk) begin
        if (softRst) begin
            wue_q   <= `PCRR_RST_WUE;
            lifetime_counter_wake_enable_q <= 1'b0;
        end else if (wr && ofs == `PCRR_OFS_WUE_HI) begin
            wue_q <= busReq.word ? wd[15:8] : wd[7:0];
            if (busReq.word)
                lifetime_counter_wake_enable_q <= wd[7];
        end else if (wr && !busReq.word && ofs == `PCRR_OFS_WUE_LO) begin
            lifetime_counter_wake_enable_q <= wd[7];
        end
    end

    // Condition inputs come from analog comparators, so synchronise them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hotCond_m <= 1'b0;
            hotCond_q <= 1'b0;
        end else begin
            hotCond_m <= hotCondition;
            hotCond_q <= hotCond_m;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            uvCond_m <= 1'b0;
            uvCond_q <= 1'b0;
        end else begin
            uvCond_m <= undervoltCondition;
            uvCond_q <= uvCond_m;
        end
    end

    logic [7:0] srHiClr;
    logic [7:0] srLoClr;
    always_comb begin
        srHiClr = 8'h00;
        srLoClr = 8'h00;
        if (wr && ofs == `PCRR_OFS_SR_HI) begin
            srHiClr = busReq.word ? wd[15:8] : wd[7:0];
            if (busReq.word)
                srLoClr = wd[7:0];
        end else if (wr && !busReq.word && ofs == `PCRR_OFS_SR_LO) begin
            srLoClr = wd[7:0];
        end
    end

    // Cause flags survive the soft reset so software can see why it happened
    always_ff @(posedge core_clk) begin
        if (rst) begin
            srHi_q <= 8'h00;
            srLo_q <= 8'h00;
        end else begin
            srHi_q[5:0] <= (srHi_q[5:0] & ~srHiClr[5:0]) | resetCauseSet;
            if (hwrLatch_q)
                srHi_q[`PCRR_BIT_HWR_FLAG] <= 1'b1;
            srHi_q[7:6] <= {hotCond_q, uvCond_q};
            srLo_q <= (srLo_q & ~srLoClr) | wakeSourceSet;
        end
    end

    // Pending interrupts: a new rising condition wins over a same-cycle clear
    // The mirrored flag doubles as the previous sample for edge detection
    always_ff @(posedge core_clk) begin
        if (softRst) begin
            hotPend_q <= 1'b0;
        end else if (hotCond_q && !srHi_q[`PCRR_BIT_HOT_FLAG]) begin
            hotPend_q <= 1'b1;
        end else if (srHiClr[`PCRR_BIT_HOT_FLAG]) begin
            hotPend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (softRst) begin
            uvPend_q <= 1'b0;
        end else if (uvCond_q && !srHi_q[`PCRR_BIT_UV_FLAG]) begin
            uvPend_q <= 1'b1;
        end else if (srHiClr[`PCRR_BIT_UV_FLAG]) begin
            uvPend_q <= 1'b0;
        end
    end

    // Reset pulse counter runs on the raw reset only, so it outlives the soft reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hwrCnt_q   <= '0;
            hwrLatch_q <= 1'b0;
        end else if (hwrFire) begin
            hwrCnt_q   <= PULSE_W'(`PCRR_HWR_PULSE_CYC);
            hwrLatch_q <= 1'b1;
        end else if (hwrCnt_q != '0) begin
            hwrCnt_q   <= hwrCnt_q - 1'b1;
            hwrLatch_q <= 1'b0;
        end
    end

    // Read data registered one cycle after the access
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (rd) begin
            if (ofs == `PCRR_OFS_CTL && busReq.word)
                rdata_q <= {8'h00, hotDis_q, uvDis_q, 2'b00, tickSel_q, mode_q};
            else if (ofs == `PCRR_OFS_SR_HI)
                rdata_q <= busReq.word ? {srHi_q, srLo_q} : {8'h00, srHi_q};
            else if (ofs == `PCRR_OFS_SR_LO && !busReq.word)
                rdata_q <= {8'h00, srLo_q};
            else if (ofs == `PCRR_OFS_TICK_DIVIDER_VALUE && busReq.word)
                rdata_q <= tick_divider_value_q;
            else if (ofs == `PCRR_OFS_WUE_HI)
                rdata_q <= busReq.word ? {wue_q, lifetime_counter_wake_enable_q, 7'h00} : {8'h00, wue_q};
            else if (ofs == `PCRR_OFS_WUE_LO && !busReq.word)
                rdata_q <= {8'h00, lifetime_counter_wake_enable_q, 7'h00};
            else if (ofs == `PCRR_OFS_TRIM_HI)
                rdata_q <= busReq.word ? {trimStatusFlag, 2'b00, trimmedTickDivider}
                                       : {8'h00, trimStatusFlag, 2'b00, trimmedTickDivider[12:8]};
            else if (ofs == `PCRR_OFS_TRIM_LO && !busReq.word)
                rdata_q <= {8'h00, trimmedTickDivider[7:0]};
            else
                rdata_q <= 16'h0000;
        end
    end

    assign busRdata = rdata_q;

    always_comb begin
        case (tickSel_q)
            2'b00:   tickFactor = 4'h1;
            2'b01:   tickFactor = 4'h2;
            2'b10:   tickFactor = 4'h4;
            default: tickFactor = 4'h8;
        endcase
    end

    always_comb begin
        case (mode_q)
            PCRR_MODE_NORMAL:   opMode = PCRR_MODE_NORMAL;
            PCRR_MODE_STOP:     opMode = PCRR_MODE_STOP;
            PCRR_MODE_SLEEP:    opMode = PCRR_MODE_SLEEP;
            default:            opMode = crankingEnable ? PCRR_MODE_CRANKING : PCRR_MODE_STOP;
        endcase
    end

    assign hotInterrupt              = hotPend_q && !hotDis_q;
    assign undervoltInterrupt        = uvPend_q && !uvDis_q;
    assign tickDividerValue          = tick_divider_value_q;
    assign wakeEnableHigh            = wue_q;
    assign lifetimeCounterWakeEnable = lifetime_counter_wake_enable_q;
    assign dieLogicReset             = hwrLatch_q;
    assign analogResetOutN           = (hwrCnt_q == '0);
endmodule
`default_nettype wire

// [tb/pcrr_host_model.sv]
// Purpose: Microcontroller side of the register bus
// Assumes: One request per two cycles, driven at the falling edge
// Notes:   Idle lines carry inverted leftovers so stale decode shows up
`timescale 1ns/1ps
`default_nettype none
module pcrr_host_model
    import pcrr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic [15:0] busRdata,
    output var pcrr_req_t   busReq,
    output var logic        blocking
);
    initial begin
        busReq   = '0;
        blocking = 1'b1;
    end
    task automatic wr(input logic b, input logic [15:0] a, input logic [15:0] d, input logic w);
        @(negedge core_clk);
        blocking = b;
        busReq   = '{1'b1, 1'b1, w, a, (a[7:0] == 8'h00) ? (d & 16'hEFEF) : d};
        @(negedge core_clk);
        busReq   = '{1'b0, 1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge core_clk);
        blocking = 1'b1;
        busReq   = '{1'b1, 1'b0, 1'b1, a, ~a};
        @(negedge core_clk);
        d        = busRdata;
        busReq   = '{1'b0, 1'b0, 1'b0, ~a, a};
    endtask
endmodule
`default_nettype wire

// [tb/pcrr_regs_chk.sv]
// Purpose: Port-level checks of the control register bank
// Assumes: Single-cycle bus, guards only apply to the write carrying them
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module pcrr_regs_chk
    import pcrr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire pcrr_req_t   busReq,
    input wire logic        blocking,
    input wire logic [15:0] busRdata,
    input wire logic        busHit,
    input wire logic        crankingEnable,
    input wire logic        trimStatusFlag,
    input wire logic [12:0] trimmedTickDivider,
    input wire pcrr_mode_t  opMode,
    input wire logic [3:0]  tickFactor,
    input wire logic        dieLogicReset,
    input wire logic        analogResetOutN
);
    logic        acc;
    logic        ctlWr;
    logic        hwrWr;
    logic [15:0] wd;
    assign acc   = busReq.valid && busHit && busReq.word;
    assign wd    = busReq.wdata;
    assign ctlWr = acc && busReq.write && busReq.addr[7:0] == 8'h00;
    assign hwrWr = ctlWr && wd[13] && wd[5];
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_hit_decode:
        assert property (busHit == (busReq.valid && busReq.addr[15:8] == (blocking ? 8'h02 : 8'h03)))
        else $error("window decode wrong");
    chk_ctl_readzero:
        assert property (acc && !busReq.write && busReq.addr[7:0] == 8'h00 |=> busRdata[15:8] == 8'h00 && !busRdata[5])
        else $error("control readback bits not zero");
    chk_mode_load:
        assert property (ctlWr && wd[9:8] == 2'b11 |=> opMode == (($past(wd[1:0]) == 2'b11 && !crankingEnable) ?
            PCRR_MODE_STOP : pcrr_mode_t'($past(wd[1:0]))))
        else $error("mode not loaded");
    chk_mode_keep:
        assert property (ctlWr && wd[9:8] != 2'b11 && !dieLogicReset |=> $stable(opMode))
        else $error("mode changed without guard");
    chk_factor_load:
        assert property (ctlWr && wd[11:10] == 2'b11 |=> tickFactor == 4'h1 << $past(wd[3:2]))
        else $error("tick factor not loaded");
    chk_factor_keep:
        assert property (ctlWr && wd[11:10] != 2'b11 && !dieLogicReset |=> $stable(tickFactor))
        else $error("tick factor changed without guard");
    chk_reset_pulse:
        assert property (hwrWr |=> dieLogicReset ##1 !dieLogicReset)
        else $error("die reset pulse wrong");
    chk_reset_out_low:
        assert property (hwrWr |=> !analogResetOutN [*8] ##1 analogResetOutN)
        else $error("external reset width wrong");
    chk_reset_ignored:
        assert property (ctlWr && !(wd[13] && wd[5]) && !dieLogicReset |=> !dieLogicReset)
        else $error("unguarded reset acted");
    chk_trim_read:
        assert property (acc && !busReq.write && busReq.addr[7:0] == 8'h0E |=>
            busRdata == {trimStatusFlag, 2'b00, trimmedTickDivider})
        else $error("trim word wrong");
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the control register bank
// Assumes: Trim inputs held constant; conditions settle within five cycles
// Notes:   Each scenario checks its own results before returning
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pcrr_pkg::*;
    logic        core_clk;
    logic        rst;
    pcrr_req_t   busReq;
    logic        blocking;
    logic [15:0] busRdata;
    logic        busHit;
    logic        crankingEnable;
    logic        hotCondition;
    logic        undervoltCondition;
    logic [5:0]  resetCauseSet;
    logic [7:0]  wakeSourceSet;
    pcrr_mode_t  opMode;
    logic [3:0]  tickFactor;
    logic [15:0] tickDividerValue;
    logic [7:0]  wakeEnableHigh;
    logic        lifetimeCounterWakeEnable;
    logic        hotInterrupt;
    logic        undervoltInterrupt;
    logic        dieLogicReset;
    logic        analogResetOutN;
    logic [15:0] v;
    int          n;
    int          bad_count;
    int          compares;
    pcrr_regs #(.PULSE_W(4)) pcrr_regs_inst (.core_clk, .rst, .busReq, .blocking, .busRdata, .busHit, .crankingEnable,
        .hotCondition, .undervoltCondition, .resetCauseSet, .wakeSourceSet, .trimStatusFlag(1'b1),
        .trimmedTickDivider(13'h1A5C), .opMode, .tickFactor, .tickDividerValue, .wakeEnableHigh,
        .lifetimeCounterWakeEnable, .hotInterrupt, .undervoltInterrupt, .dieLogicReset, .analogResetOutN);
    pcrr_host_model pcrr_host_model_inst (.core_clk, .busRdata, .busReq, .blocking);
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask
    task automatic w(input logic b, input logic [15:0] a, input logic [15:0] d, input logic wd = 1'b1);
        pcrr_host_model_inst.wr(b, a, d, wd);
    endtask
    task automatic r(input logic [15:0] a);
        pcrr_host_model_inst.rd(a, v);
    endtask
    task automatic t_window;
        r(16'h0200); chk("ctl reset", v, 16'h0000);
        w(1'b1, 16'h0200, 16'h0303); chk("mode blk", 16'(opMode), 16'(PCRR_MODE_STOP));
        w(1'b0, 16'h0300, 16'h0302); chk("mode nonblk", 16'(opMode), 16'(PCRR_MODE_SLEEP));
        w(1'b1, 16'h0300, 16'h0300); chk("mode miss", 16'(opMode), 16'(PCRR_MODE_SLEEP));
        r(16'h0200); chk("ctl read", v, 16'h0002);
    endtask
    task automatic t_fields;
        for (int k = 0; k < 4; k++) begin
            w(1'b1, 16'h0200, 16'h0C00 | 16'(k << 2)); chk("factor", 16'(tickFactor), 16'(1 << k));
            chk("mode kept", 16'(opMode), 16'(PCRR_MODE_SLEEP));
        end
        w(1'b1, 16'h0200, 16'h0800); chk("factor guard", 16'(tickFactor), 16'h0008);
        for (int m = 0; m < 3; m++) begin
            w(1'b1, 16'h0200, 16'h0300 | 16'(m)); chk("mode code", 16'(opMode), 16'(m));
        end
        w(1'b1, 16'h0200, 16'h0201); chk("mode guard", 16'(opMode), 16'(PCRR_MODE_SLEEP));
        crankingEnable = 1'b1;
        w(1'b1, 16'h0200, 16'h0303); chk("cranking", 16'(opMode), 16'(PCRR_MODE_CRANKING));
        w(1'b1, 16'h0200, 16'h0300);
        crankingEnable = 1'b0;
    endtask
    task automatic t_irq;
        hotCondition = 1'b1;
        undervoltCondition = 1'b1;
        repeat (5) @(negedge core_clk);
        chk("irq on", {14'h0, hotInterrupt, undervoltInterrupt}, 16'h0003);
        w(1'b1, 16'h0200, 16'h00C0); chk("irq noguard", {14'h0, hotInterrupt, undervoltInterrupt}, 16'h0003);
        w(1'b1, 16'h0200, 16'h80C0); chk("hot off", {14'h0, hotInterrupt, undervoltInterrupt}, 16'h0001);
        w(1'b1, 16'h0200, 16'h4040); chk("uv off", {14'h0, hotInterrupt, undervoltInterrupt}, 16'h0000);
        r(16'h0202); chk("live flags", v & 16'hC000, 16'hC000);
        w(1'b1, 16'h0200, 16'hC000);
        hotCondition = 1'b0;
        undervoltCondition = 1'b0;
        repeat (5) @(negedge core_clk);
        chk("pending kept", {14'h0, hotInterrupt, undervoltInterrupt}, 16'h0003);
        w(1'b1, 16'h0202, 16'hC000); chk("pending clr", {14'h0, hotInterrupt, undervoltInterrupt}, 16'h0000);
    endtask
    task automatic t_status;
        resetCauseSet = 6'h01;
        wakeSourceSet = 8'h08;
        @(negedge core_clk);
        resetCauseSet = 6'h00;
        wakeSourceSet = 8'h00;
        r(16'h0202); chk("flags set", v, 16'h0108);
        w(1'b1, 16'h0202, 16'h0000); r(16'h0202); chk("flags kept", v, 16'h0108);
        w(1'b1, 16'h0202, 16'h0108); r(16'h0202); chk("flags clr", v, 16'h0000);
    endtask
    task automatic t_data;
        w(1'b1, 16'h0204, 16'hA5C3); r(16'h0204); chk("tick_divider_value", v, 16'hA5C3);
        chk("tick_divider_value out", tickDividerValue, 16'hA5C3);
        w(1'b1, 16'h0204, 16'h005A, 1'b0); r(16'h0204); chk("tick_divider_value byte", v, 16'hA5C3);
        w(1'b1, 16'h020E, 16'h0000); r(16'h020E); chk("trim", v, 16'h9A5C);
        w(1'b1, 16'h0206, 16'hFFFF); r(16'h0206); chk("wake en", v, 16'hFF80);
        chk("wake out", {wakeEnableHigh, 7'h0, lifetimeCounterWakeEnable}, 16'hFF01);
    endtask
    task automatic t_reset;
        w(1'b1, 16'h0200, 16'h0C0C);
        w(1'b1, 16'h0200, 16'h0020); chk("hwr noguard", {15'h0, analogResetOutN}, 16'h0001);
        // Only the guarded command may reset the die from normal mode
        w(1'b1, 16'h0200, 16'h2020); chk("die rst", {15'h0, dieLogicReset}, 16'h0001);
        n = 0;
        while (!analogResetOutN && n < 20) begin
            n++;
            @(negedge core_clk);
        end
        chk("rst width", 16'(n), 16'h0008);
        r(16'h0200); chk("ctl cleared", v, 16'h0000);
        chk("cleared out", {tickFactor, wakeEnableHigh, 4'h0}, 16'h1000);
        r(16'h0202); chk("hwr flag", v & 16'h2000, 16'h2000);
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        repeat (4000) @(posedge core_clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {rst, crankingEnable, hotCondition, undervoltCondition, resetCauseSet, wakeSourceSet} = 18'h2_0000;
        bad_count = 0;
        compares = 0;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        t_window();
        t_fields();
        t_irq();
        t_status();
        t_data();
        t_reset();
        tally_and_finish();
    end
endmodule
bind pcrr_regs pcrr_regs_chk pcrr_regs_chk_inst (.core_clk, .rst, .busReq, .blocking, .busRdata, .busHit,
    .crankingEnable, .trimStatusFlag, .trimmedTickDivider, .opMode, .tickFactor, .dieLogicReset, .analogResetOutN);
`default_nettype wire
